// ---- design/fifo_ctl_regs.svh ----
// Register offsets, field positions, reset values and sizes of the FIFO pair control.
`ifndef FIFO_CTL_REGS_SVH
`define FIFO_CTL_REGS_SVH
// ********************************************************
// Geometry
// ********************************************************
`define FIFO_DEPTH 5'h10
`define PTR_W 4
`define CNT_W 5
`define IDLE_BITS 4'h8
// ********************************************************
// Bus map
// ********************************************************
`define ADDR_W 12
`define OFS_CTRL_LOWER 12'h000
`define OFS_CTRL_UPPER 12'h004
`define OFS_COUNT 12'h008
// Lower control register fields.
`define F_EN1 0
`define F_EN2 1
`define F_RST1 2
`define F_RST2 3
`define F_SAVE 4
`define F_RELOAD 5
`define F_LOST 6
// Upper control register fields.
`define F_SEL 0
`define F_TXIRQ_EN 1
`define F_REQ 2
`define F_IDLE_EN 3
`define F_LOST_EN 4
// Count register: first FIFO in bits 7:0, second in 15:8.
`define F_CNT2 8
`define RESET_UPPER 8'h04
// Per-bit reset values of the upper control register.
`define RESET_SEL 1'b0
`define RESET_TXIRQ_EN 1'b0
`define RESET_REQ 1'b1
`define RESET_IDLE_EN 1'b0
`define RESET_LOST_EN 1'b0
`define RESET_LOWER 8'h00
`define ZERO_WORD 32'h0000_0000
`endif

// ---- design/fifo_ctl_pkg.sv ----
// Types shared by the FIFO pair control modules.
package fifo_ctl_pkg;
	typedef enum logic {
		RELOAD_IDLE = 1'b0,
		RELOAD_BUSY = 1'b1
	} reload_state_t;
	typedef logic [3:0] ptr_t;
	typedef logic [4:0] cnt_t;
endpackage : fifo_ctl_pkg

// ---- design/fifo_ptr_if.sv ----
// Pointer and count bundle between the control logic and one FIFO pointer unit.
`timescale 1ns/1ns
interface fifo_ptr_if;
	import fifo_ctl_pkg::*;
	logic push;
	logic pop;
	logic clear;
	logic reload;
	ptr_t reload_ptr;
	ptr_t wptr;
	ptr_t rptr;
	cnt_t count;
	logic full;
	modport ctl (output push, pop, clear, reload, reload_ptr, input wptr, rptr, count, full);
	modport unit (input push, pop, clear, reload, reload_ptr, output wptr, rptr, count, full);
endinterface : fifo_ptr_if

// ---- design/fifo_pointer_unit.sv ----
// Read and write pointers and valid count of one FIFO.
`timescale 1ns/1ns
`include "fifo_ctl_regs.svh"
module fifo_pointer_unit (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Control side.
	fifo_ptr_if.unit port
);
	import fifo_ctl_pkg::*;

	// Pointers move only on clear, reload and accepted pushes and pops, so a disabled FIFO changes only by clear or reload.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port.wptr <= '0;
			port.rptr <= '0;
			port.count <= '0;
		end else if (port.clear) begin
			port.wptr <= '0;
			port.rptr <= '0;
			port.count <= '0;
		end else if (port.reload) begin
			// Bytes between the saved pointer and the current one become pending again.
			port.rptr <= port.reload_ptr;
			port.count <= port.count + cnt_t'(port.rptr - port.reload_ptr);
		end else begin
			port.wptr <= port.wptr + ptr_t'(port.push);
			port.rptr <= port.rptr + ptr_t'(port.pop);
			port.count <= port.count + cnt_t'(port.push) - cnt_t'(port.pop);
		end
	end

	assign port.full = (port.count == `FIFO_DEPTH);
endmodule : fifo_pointer_unit

// ---- design/serial_fifo_pair_control.sv ----
// Control of the transmit and receive FIFO pair of a serial interface.
`timescale 1ns/1ns
`include "fifo_ctl_regs.svh"
module serial_fifo_pair_control (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// APB slave.
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial shift logic.
	input wire logic tx_push,
	input wire logic tx_pop,
	input wire logic rx_push,
	input wire logic rx_pop,
	input wire logic rx_error,
	input wire logic rx_bit_tick,
	input wire logic transmit_enable,
	input wire logic tx_busy,
	input wire logic rx_irq_enable,
	// Status towards the shift logic and interrupt controller.
	output logic tx_send_ready,
	output logic tx_fifo_irq,
	output logic rx_idle_detect,
	output logic rx_idle_irq,
	output logic role_out,
	output fifo_ctl_pkg::ptr_t [1:0] fifo_wptr,
	output fifo_ctl_pkg::ptr_t [1:0] fifo_rptr
);
	import fifo_ctl_pkg::*;

	// ********************************************************
	// State
	// ********************************************************
	logic [1:0] fifo_enable;
	logic fifo_role_select;
	logic tx_fifo_irq_enable;
	logic tx_data_request_flag;
	logic rx_idle_detect_enable;
	logic lost_detect_enable;
	logic retransmit_lost_flag, lost_armed;
	reload_state_t reload_state;
	ptr_t saved_ptr;
	logic [3:0] idle_cnt;
	logic idle_done;
	logic [1:0] push_v, pop_v, clear_v;
	ptr_t [1:0] wptr_v, rptr_v;
	cnt_t [1:0] cnt_v;
	logic [1:0] full_v;
	fifo_ptr_if ports [1:0] ();

	// ********************************************************
	// Role mux
	// ********************************************************
	logic tx_i, rx_i, tx_empty;
	// Select zero makes the first FIFO transmit and the second receive.
	assign tx_i = fifo_role_select;
	assign rx_i = ~fifo_role_select;
	assign tx_empty = (cnt_v[tx_i] == '0);

	// ********************************************************
	// APB decode
	// ********************************************************
	logic setup, access, wr_lower, wr_upper, wr_open, mapped;
	logic [7:0] wd;
	logic [31:0] next_prdata;
	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign wd = pwdata[7:0];
	assign wr_lower = access & pwrite & (paddr == `OFS_CTRL_LOWER);
	assign wr_upper = access & pwrite & (paddr == `OFS_CTRL_UPPER);
	// Ordinary writes are held off while a reload is pending; resets still pass.
	assign wr_open = (reload_state == RELOAD_IDLE);

	// Read data is built in the setup cycle so that the access phase needs no wait.
	always_comb begin
		next_prdata = `ZERO_WORD;
		mapped = 1'b1;
		if (paddr == `OFS_CTRL_LOWER) begin
			next_prdata[`F_EN1] = fifo_enable[0];
			next_prdata[`F_EN2] = fifo_enable[1];
			next_prdata[`F_SAVE] = 1'b0;
			next_prdata[`F_RELOAD] = reload_state;
			next_prdata[`F_LOST] = retransmit_lost_flag;
		end else if (paddr == `OFS_CTRL_UPPER) begin
			next_prdata[`F_SEL] = fifo_role_select;
			next_prdata[`F_TXIRQ_EN] = tx_fifo_irq_enable;
			next_prdata[`F_REQ] = tx_data_request_flag;
			next_prdata[`F_IDLE_EN] = rx_idle_detect_enable;
			next_prdata[`F_LOST_EN] = lost_detect_enable;
		end else if (paddr == `OFS_COUNT) begin
			next_prdata[`F_CNT2-1:0] = 8'(cnt_v[0]);
			next_prdata[`F_CNT2+7:`F_CNT2] = 8'(cnt_v[1]);
		end else begin
			mapped = 1'b0;
		end
	end

	// Zero-wait slave: ready and the answer arrive in the first access cycle.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `ZERO_WORD;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite) ? next_prdata : `ZERO_WORD;
		end
	end

	// ********************************************************
	// Lower control register
	// ********************************************************
	logic save_ok, reload_ok;
	// Reset bits act as one-cycle pulses and are never stored, so they read zero.
	assign clear_v = wr_lower ? {wd[`F_RST2], wd[`F_RST1]} : 2'b00;
	assign save_ok = wr_lower & wr_open & wd[`F_SAVE] & tx_empty;
	// Reload needs a disabled, idle transmit FIFO whose saved data is intact.
	assign reload_ok = wr_lower & wr_open & wd[`F_RELOAD] & ~fifo_enable[tx_i] & ~tx_busy
		& ~retransmit_lost_flag;

	// Enables: a receive error drops the receive FIFO enable and holds it down.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fifo_enable <= 2'b00;
		end else begin
			if (wr_lower & wr_open) begin
				fifo_enable <= wd[`F_EN2:`F_EN1];
			end
			if (rx_error) begin
				fifo_enable[rx_i] <= 1'b0;
			end
		end
	end

	// Saved pointer for retransmission.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			saved_ptr <= '0;
		end else if (save_ok) begin
			saved_ptr <= rptr_v[tx_i];
		end
	end

	// The first write after a save fills the saved slot itself; only a later pass over it loses data.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lost_armed <= 1'b0;
		end else if (clear_v[tx_i] | save_ok) begin
			lost_armed <= push_v[tx_i] & ~clear_v[tx_i];
		end else if (push_v[tx_i]) begin
			lost_armed <= 1'b1;
		end
	end

	// Reload lasts one cycle: the copy is issued and the bit falls back to zero.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reload_state <= RELOAD_IDLE;
		end else begin
			case (reload_state)
				RELOAD_IDLE: begin
					if (reload_ok) begin
						reload_state <= RELOAD_BUSY;
					end
				end
				RELOAD_BUSY: begin
					reload_state <= RELOAD_IDLE;
				end
				default: begin
					reload_state <= RELOAD_IDLE;
				end
			endcase
		end
	end

	// Lost flag: a write over the saved slot sets it, and the set beats a clear.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			retransmit_lost_flag <= 1'b0;
		end else if (lost_detect_enable & lost_armed & push_v[tx_i] & (wptr_v[tx_i] == saved_ptr)) begin
			retransmit_lost_flag <= 1'b1;
		end else if ((clear_v != 2'b00) | save_ok) begin
			retransmit_lost_flag <= 1'b0;
		end
	end

	// ********************************************************
	// Upper control register
	// ********************************************************
	// Plain enable bits; a FIFO reset leaves them alone.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_fifo_irq_enable <= `RESET_TXIRQ_EN;
			rx_idle_detect_enable <= `RESET_IDLE_EN;
			lost_detect_enable <= `RESET_LOST_EN;
		end else if (wr_upper & wr_open) begin
			tx_fifo_irq_enable <= wd[`F_TXIRQ_EN];
			rx_idle_detect_enable <= wd[`F_IDLE_EN];
			lost_detect_enable <= wd[`F_LOST_EN];
		end
	end

	// Role select is untouched by FIFO reset and moves only with both FIFOs off.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fifo_role_select <= `RESET_SEL;
		end else if (wr_upper & wr_open & tx_data_request_flag & (fifo_enable == 2'b00)) begin
			fifo_role_select <= wd[`F_SEL];
		end
	end

	// Request flag: empty or reset sets it; a zero write while data waits, or full, clears it.
	// A one write is ignored, so a read-back-and-write of the register is harmless.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_data_request_flag <= `RESET_REQ;
		end else if (tx_empty | clear_v[tx_i]) begin
			tx_data_request_flag <= 1'b1;
		end else if ((wr_upper & wr_open & ~wd[`F_REQ]) | full_v[tx_i]) begin
			tx_data_request_flag <= 1'b0;
		end
	end

	// ********************************************************
	// FIFO pointer units
	// ********************************************************
	// Pushes and pops pass only to an enabled FIFO, so disabling freezes it except for FIFO reset and reload.
	always_comb begin
		push_v = 2'b00;
		pop_v = 2'b00;
		push_v[tx_i] = tx_push & fifo_enable[tx_i] & ~full_v[tx_i];
		pop_v[tx_i] = tx_pop & fifo_enable[tx_i] & ~tx_empty;
		push_v[rx_i] = rx_push & fifo_enable[rx_i] & ~full_v[rx_i] & ~rx_error;
		pop_v[rx_i] = rx_pop & fifo_enable[rx_i] & (cnt_v[rx_i] != '0);
	end

	// Depth comes from the header size; pointer and count widths come from the package types.
	for (genvar i = 0; i < 2; i++) begin : g_fifo
		assign ports[i].push = push_v[i];
		assign ports[i].pop = pop_v[i];
		assign ports[i].clear = clear_v[i];
		assign ports[i].reload = (reload_state == RELOAD_BUSY) & (tx_i == 1'(i));
		assign ports[i].reload_ptr = saved_ptr;
		assign wptr_v[i] = ports[i].wptr;
		assign rptr_v[i] = ports[i].rptr;
		assign cnt_v[i] = ports[i].count;
		assign full_v[i] = ports[i].full;
		assign fifo_wptr[i] = ports[i].wptr;
		assign fifo_rptr[i] = ports[i].rptr;
		fifo_pointer_unit u_unit (
			.clock(clock),
			.reset_n(reset_n),
			.port(ports[i])
		);
	end

	// ********************************************************
	// Receive idle detection
	// ********************************************************
	logic idle_hold, idle_fire;
	// Any receive activity, an empty or disabled FIFO restarts the count.
	assign idle_hold = rx_push | rx_pop | ~fifo_enable[rx_i] | ~rx_idle_detect_enable
		| (cnt_v[rx_i] == '0);
	assign idle_fire = ~idle_hold & rx_bit_tick & ~idle_done & (idle_cnt == `IDLE_BITS);

	// Counts bit times; the ninth silent tick fires once per idle period.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			idle_cnt <= '0;
			idle_done <= 1'b0;
		end else if (idle_hold) begin
			idle_cnt <= '0;
			idle_done <= 1'b0;
		end else if (rx_bit_tick & ~idle_done) begin
			if (idle_cnt == `IDLE_BITS) begin
				idle_done <= 1'b1;
			end else begin
				idle_cnt <= idle_cnt + 4'h1;
			end
		end
	end

	// ********************************************************
	// Registered outputs
	// ********************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_fifo_irq <= 1'b0;
			rx_idle_detect <= 1'b0;
			rx_idle_irq <= 1'b0;
			tx_send_ready <= 1'b0;
			role_out <= 1'b0;
		end else begin
			tx_fifo_irq <= tx_data_request_flag & tx_fifo_irq_enable;
			rx_idle_detect <= idle_fire;
			rx_idle_irq <= idle_fire & rx_irq_enable;
			tx_send_ready <= fifo_enable[tx_i] & ~tx_empty & transmit_enable;
			role_out <= fifo_role_select;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_irq_follows_request: assert property (tx_fifo_irq == $past(tx_data_request_flag & tx_fifo_irq_enable))
		else $error("irq does not follow request");
	a_select_held: assert property (!tx_data_request_flag |=> $stable(fifo_role_select))
		else $error("select moved while request low");
	a_select_when_off: assert property (!$stable(fifo_role_select) |-> $past(fifo_enable) == 2'b00)
		else $error("select moved with a FIFO enabled");
	a_request_on_empty: assert property (tx_empty |=> tx_data_request_flag)
		else $error("request not set on empty");
	a_lost_needs_enable: assert property ($rose(retransmit_lost_flag) |-> $past(lost_detect_enable))
		else $error("lost set without detect enable");
	a_lost_cleared_reset: assert property ((clear_v != 2'b00) && !push_v[tx_i] |=> !retransmit_lost_flag)
		else $error("lost not cleared by reset");
	a_reload_one_cycle: assert property (reload_state == RELOAD_BUSY |=> reload_state == RELOAD_IDLE)
		else $error("reload did not self clear");
	a_reload_blocks: assert property (reload_state == RELOAD_BUSY |=> $stable(fifo_enable) || $past(rx_error))
		else $error("write passed during reload");
	a_save_when_empty: assert property (!$stable(saved_ptr) |-> $past(tx_empty))
		else $error("save taken with data pending");
	a_reset_zero_count: assert property (clear_v[0] |=> cnt_v[0] == '0 ##1 cnt_v[0] <= 5'h01)
		else $error("reset left data count");
	a_rx_error_disables: assert property (rx_error |=> !fifo_enable[rx_i])
		else $error("receive FIFO stays enabled on error");
	a_idle_after_quiet: assert property (rx_idle_detect |-> $past(idle_cnt) == `IDLE_BITS && $past(rx_bit_tick))
		else $error("idle flagged too early");

	c_request_irq: cover property (tx_fifo_irq);
	c_reload: cover property (reload_state == RELOAD_BUSY);
	c_idle: cover property (rx_idle_irq);
	c_lost: cover property ($rose(retransmit_lost_flag));
endmodule : serial_fifo_pair_control

// ---- dv/tx_serial_model.sv ----
// Behavioural model of the serial shift logic that drains the transmit FIFO and gives the receive bit tick.
`timescale 1ns/1ns
module tx_serial_model #(
	parameter int BIT_CYCLES = 4,
	parameter int FRAME_BITS = 10
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// FIFO side.
	input wire logic tx_send_ready,
	output logic tx_pop,
	output logic tx_busy,
	output logic rx_bit_tick
);
	int bit_cnt;
	int frame_cnt;
	// ********************************************************
	// Bit timing
	// ********************************************************
	// The baud generator runs free, so the tick never stops between frames.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 0;
			rx_bit_tick <= 1'b0;
		end else begin
			bit_cnt <= (bit_cnt == BIT_CYCLES - 1) ? 0 : bit_cnt + 1;
			rx_bit_tick <= (bit_cnt == BIT_CYCLES - 1);
		end
	end
	// ********************************************************
	// Transmitter
	// ********************************************************
	// One byte is taken as soon as it is offered, then the shifter stays busy for a whole frame.
	// The ready flag lags by a cycle, so a new byte is only taken once busy has dropped.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_pop <= 1'b0;
			tx_busy <= 1'b0;
			frame_cnt <= 0;
		end else begin
			tx_pop <= 1'b0;
			if (tx_busy) begin
				frame_cnt <= frame_cnt - 1;
				tx_busy <= (frame_cnt > 1);
			end else if (tx_send_ready && !tx_pop) begin
				tx_pop <= 1'b1;
				tx_busy <= 1'b1;
				frame_cnt <= FRAME_BITS * BIT_CYCLES;
			end
		end
	end
endmodule : tx_serial_model

// ---- dv/serial_fifo_pair_control_tb_top.sv ----
// Self-checking testbench of the FIFO pair control, driven over APB and the serial strobes.
`timescale 1ns/1ns
`include "fifo_ctl_regs.svh"
module serial_fifo_pair_control_tb_top;
	import fifo_ctl_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [`ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic tx_push = 1'b0;
	logic rx_push = 1'b0;
	logic rx_error = 1'b0;
	logic rx_pop = 1'b0;
	logic transmit_enable = 1'b0;
	logic rx_irq_enable = 1'b0;
	logic tx_pop, tx_busy, rx_bit_tick;
	logic tx_send_ready, tx_fifo_irq, rx_idle_detect, rx_idle_irq, role_out;
	ptr_t [1:0] fifo_wptr;
	ptr_t [1:0] fifo_rptr;
	logic [32:0] exp_q[$];
	int err_count = 0;
	int n_compared = 0;
	int seed = 52836;
	int ticks;
	logic [7:0] lost_exp;
	// ********************************************************
	// Clock and instances
	// ********************************************************
	initial begin
		forever #4 clock = ~clock;
	end
	serial_fifo_pair_control dut (.clock(clock), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_push(tx_push), .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop),
		.rx_error(rx_error), .rx_bit_tick(rx_bit_tick), .transmit_enable(transmit_enable),
		.tx_busy(tx_busy), .rx_irq_enable(rx_irq_enable), .tx_send_ready(tx_send_ready),
		.tx_fifo_irq(tx_fifo_irq), .rx_idle_detect(rx_idle_detect), .rx_idle_irq(rx_idle_irq),
		.role_out(role_out), .fifo_wptr(fifo_wptr), .fifo_rptr(fifo_rptr));
	tx_serial_model shifter (.clock(clock), .reset_n(reset_n), .tx_send_ready(tx_send_ready),
		.tx_pop(tx_pop), .tx_busy(tx_busy), .rx_bit_tick(rx_bit_tick));
	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// One APB transfer; the expected read word goes on the queue before the answer can come.
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($random(seed)), d};
		if (!w) begin
			exp_q.push_back(e);
		end
		@(posedge clock);
		penable <= 1'b1;
		// The wait for the answer ends when pready is seen high; the watchdog catches a slave that never answers.
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Bytes written into the transmit FIFO on consecutive cycles.
	task automatic push_tx(input int count);
		for (int i = 0; i < count; i++) begin
			@(posedge clock);
			tx_push <= 1'b1;
		end
		@(posedge clock);
		tx_push <= 1'b0;
	endtask : push_tx
	// Lets the shifter take exactly one byte: transmit is enabled only until the first pop.
	task automatic pop_one;
		int n;
		n = 0;
		@(posedge clock);
		transmit_enable <= 1'b1;
		while (tx_pop !== 1'b1 && n < 30) begin
			@(posedge clock);
			n++;
		end
		transmit_enable <= 1'b0;
		check("pop_started", 33'(n < 30), 33'd1);
		check("send_ready", 33'(tx_send_ready), 33'd1);
		n = 0;
		while (tx_busy !== 1'b0 && n < 200) begin
			@(posedge clock);
			n++;
		end
	endtask : pop_one
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	// ********************************************************
	// Monitor and watchdog
	// ********************************************************
	// Every completed read is matched against the oldest expectation.
	always @(posedge clock) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			check("apb_read", exp_q.pop_front(), {pslverr, prdata});
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		end_of_test();
	end
	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		apb(0, `OFS_CTRL_LOWER, 8'h00, 33'h0_0000_0000);
		apb(1, `OFS_CTRL_UPPER, 8'h00, '0);
		apb(0, `OFS_CTRL_UPPER, 8'h00, 33'h0_0000_0004);
		apb(0, 12'h00C, 8'h00, 33'h1_0000_0000);
		// Role select: taken with both FIFOs off, kept by a FIFO reset, refused while enabled.
		apb(1, `OFS_CTRL_UPPER, 8'h05, '0);
		apb(1, `OFS_CTRL_LOWER, 8'h04, '0);
		apb(0, `OFS_CTRL_UPPER, 8'h00, 33'h0_0000_0005);
		check("role_out", 33'(role_out), 33'd1);
		apb(1, `OFS_CTRL_LOWER, 8'h01, '0);
		apb(1, `OFS_CTRL_UPPER, 8'h04, '0);
		apb(0, `OFS_CTRL_UPPER, 8'h00, 33'h0_0000_0005);
		apb(1, `OFS_CTRL_LOWER, 8'h00, '0);
		apb(1, `OFS_CTRL_UPPER, 8'h04, '0);
		apb(0, `OFS_CTRL_UPPER, 8'h00, 33'h0_0000_0004);
		// Overwrite of saved data, with loss detection off and then on; save goes first.
		for (int le = 0; le < 2; le++) begin
			apb(1, `OFS_CTRL_LOWER, 8'h05, '0);
			apb(1, `OFS_CTRL_LOWER, 8'h11, '0);
			apb(1, `OFS_CTRL_UPPER, le ? 8'h14 : 8'h04, '0);
			push_tx(16);
			apb(0, `OFS_CTRL_UPPER, 8'h00, le ? 33'h0_0000_0010 : 33'h0_0000_0000);
			apb(0, `OFS_COUNT, 8'h00, 33'h0_0000_0010);
			pop_one();
			push_tx(1);
			lost_exp = le ? 8'h41 : 8'h01;
			apb(0, `OFS_CTRL_LOWER, 8'h00, {25'd0, lost_exp});
			// Reload is refused once the saved data has been overwritten under detection.
			apb(1, `OFS_CTRL_LOWER, 8'h00, '0);
			apb(1, `OFS_CTRL_LOWER, 8'h20, '0);
			repeat (2) @(posedge clock);
			check("rptr_reload", 33'(fifo_rptr[0]), le ? 33'd1 : 33'd0);
			apb(1, `OFS_CTRL_LOWER, 8'h05, '0);
			apb(0, `OFS_CTRL_LOWER, 8'h00, 33'h0_0000_0001);
			apb(0, `OFS_CTRL_UPPER, 8'h00, le ? 33'h0_0000_0014 : 33'h0_0000_0004);
			apb(0, `OFS_COUNT, 8'h00, 33'h0_0000_0000);
		end
		// Save at empty, send one byte, disable, then reload the saved pointer.
		apb(1, `OFS_CTRL_UPPER, 8'h04, '0);
		apb(1, `OFS_CTRL_LOWER, 8'h11, '0);
		push_tx(3);
		pop_one();
		check("wptr", 33'(fifo_wptr[0]), 33'd3);
		apb(1, `OFS_CTRL_UPPER, 8'h00, '0);
		apb(1, `OFS_CTRL_LOWER, 8'h00, '0);
		apb(1, `OFS_CTRL_UPPER, 8'h05, '0);
		apb(0, `OFS_CTRL_UPPER, 8'h00, 33'h0_0000_0000);
		apb(1, `OFS_CTRL_UPPER, 8'h02, '0);
		apb(0, `OFS_COUNT, 8'h00, 33'h0_0000_0002);
		check("irq_quiet", 33'(tx_fifo_irq), 33'd0);
		apb(1, `OFS_CTRL_UPPER, 8'h00, '0);
		apb(1, `OFS_CTRL_LOWER, 8'h20, '0);
		apb(0, `OFS_CTRL_LOWER, 8'h00, 33'h0_0000_0000);
		apb(0, `OFS_COUNT, 8'h00, 33'h0_0000_0003);
		check("rptr", 33'(fifo_rptr[0]), 33'd0);
		// Drain after re-enabling; the empty FIFO raises the request and its interrupt.
		apb(1, `OFS_CTRL_LOWER, 8'h01, '0);
		apb(1, `OFS_CTRL_UPPER, 8'h02, '0);
		repeat (3) pop_one();
		repeat (3) @(posedge clock);
		check("tx_irq", 33'(tx_fifo_irq), 33'd1);
		// Receive idle on the second FIFO, then a receive error drops its enable.
		apb(1, `OFS_CTRL_UPPER, 8'h0C, '0);
		apb(1, `OFS_CTRL_LOWER, 8'h02, '0);
		rx_irq_enable <= 1'b1;
		@(posedge clock);
		rx_push <= 1'b1;
		@(posedge clock);
		rx_push <= 1'b0;
		ticks = 0;
		for (int i = 0; i < 200 && rx_idle_detect !== 1'b1; i++) begin
			@(posedge clock);
			ticks += int'(rx_bit_tick);
		end
		check("idle_ticks", 33'(ticks > 8 && ticks < 11), 33'd1);
		check("idle_irq", 33'(rx_idle_irq), 33'd1);
		rx_pop <= 1'b1;
		@(posedge clock);
		rx_pop <= 1'b0;
		apb(0, `OFS_COUNT, 8'h00, 33'h0_0000_0000);
		rx_error <= 1'b1;
		apb(1, `OFS_CTRL_LOWER, 8'h02, '0);
		apb(0, `OFS_CTRL_LOWER, 8'h00, 33'h0_0000_0000);
		rx_error <= 1'b0;
		apb(1, `OFS_CTRL_LOWER, 8'h02, '0);
		apb(0, `OFS_CTRL_LOWER, 8'h00, 33'h0_0000_0002);
		repeat (4) @(posedge clock);
		end_of_test();
	end
endmodule : serial_fifo_pair_control_tb_top
